// file: reset_mode_select.sv
`default_nettype none
module reset_mode_select
  import reset_mode_pkg::*;
#(
  parameter int WatchdogCycles = WATCHDOG_TIMEOUT_CYCLES,
  parameter bit Programmable = 1'b1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic irqElevated,
  input wire logic modeStrapPin,
  input wire logic watchdogService,
  input wire logic waitActive,
  input wire logic waitEntered,
  input wire logic [2:0] selfCheckFault,
  input wire logic selfCheckPass,
  input wire logic [7:0] userPortOut,
  input wire logic [15:0] progAddr,
  output logic [1:0] opMode,
  output logic modeValid,
  output logic [15:0] startVector,
  output logic selfCheckRestart,
  output logic [7:0] ledPort,
  output logic strapIsPort,
  output logic progAddrOk,
  output logic clearIrqMask,
  output logic deviceReset
);

  // ----------------------------------------
  // state record
  // ----------------------------------------
  // every flop of the block lives in this one record
  typedef struct packed {
    seq_state_t state;
    logic [1:0] sampleCnt;
    logic irqSeen;
    op_mode_t mode;
    logic modeValid;
    logic [16:0] dogCnt;
    logic [1:0] pulseCnt;
    logic deviceReset;
    logic [15:0] startVector;
    logic [7:0] led;
    logic [LED_FLASH_BIT:0] flashCnt;
    logic clearMask;
    logic restart;
  } regs_t;

  // current and next copy of the record
  regs_t stateReg;
  regs_t stateNext;

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  // inclusive address window compare
  function automatic logic inRange(input logic [15:0] a, input logic [15:0] lo,
                                   input logic [15:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction

  // mode chosen from the irq level seen in the sampling window and the strap level at the latch cycle;
  // a part without programmable memory has nothing to bootstrap
  function automatic op_mode_t pickMode(input logic irqHigh, input logic strapHigh);
    if (!irqHigh) begin
      pickMode = MODE_USER;
    end else if (Programmable && strapHigh) begin
      pickMode = MODE_BOOTSTRAP;
    end else begin
      pickMode = MODE_SELF_CHECK;
    end
  endfunction

  // first fetch address for each mode
  function automatic logic [15:0] vectorFor(input op_mode_t m);
    case (m)
      MODE_SELF_CHECK: vectorFor = SELF_CHECK_START;
      MODE_BOOTSTRAP: vectorFor = USER_MEM_START;
      MODE_USER: vectorFor = USER_VECTOR_DEFAULT;
      default: vectorFor = 16'h0000;
    endcase
  endfunction

  // power-up value of every field, led port dark
  function automatic regs_t resetValue();
    resetValue = '0;
    resetValue.state = ST_SAMPLE;
    resetValue.mode = MODE_UNSET;
    resetValue.led = LED_ALL_OFF;
  endfunction

  // ----------------------------------------
  // constants
  // ----------------------------------------
  // one shared reset image keeps the async branch constant-only
  localparam regs_t REGS_RESET = resetValue();
  // counter compare value; a short count shrinks the watchdog in sim
  localparam logic [16:0] DOG_LAST = 17'(WatchdogCycles - 1);
  // step for the flash divider, sized to it
  localparam logic [LED_FLASH_BIT:0] FLASH_STEP = {{LED_FLASH_BIT{1'b0}}, 1'b1};

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  // sample: two cycles of pin sampling after release
  // run: mode frozen, watchdog counting, led port driven
  // dog reset: stretched reset pulse, then back to sample
  // the whole record but clearMask is loaded from the reset image on the way back, so a watchdog
  // reset looks like a pin reset to the rest of the chip, clearIrqMask aside
  // a mask clear request is never dropped, whatever the state
  always_comb begin
    stateNext = stateReg;
    stateNext.restart = 1'b0;
    stateNext.clearMask = waitEntered;
    case (stateReg.state)
      ST_SAMPLE: begin
        // irq level must be seen on the sampling cycles, see board hold time
        stateNext.irqSeen = stateReg.irqSeen | irqElevated;
        // the count runs 0 then 1; the second edge closes the window
        stateNext.sampleCnt = stateReg.sampleCnt + 2'h1;
        if (stateReg.sampleCnt == STRAP_LATCH_LAST) begin
          stateNext.state = ST_RUN;
          stateNext.modeValid = 1'b1;
          // strap sampled once here only, later toggles are ignored
          stateNext.mode = pickMode(stateReg.irqSeen | irqElevated, modeStrapPin);
          stateNext.startVector = vectorFor(stateNext.mode);
        end
      end
      ST_RUN: begin
        // the watchdog counts in every run cycle, wait included, and no
        // input can stop it; only a service pulse brings it back to zero,
        // which is why waitActive is not read anywhere here
        if (watchdogService) begin
          stateNext.dogCnt = '0;
        end else if (stateReg.dogCnt == DOG_LAST) begin
          stateNext.state = ST_DOG_RESET;
          stateNext.deviceReset = 1'b1;
          stateNext.pulseCnt = '0;
        end else begin
          stateNext.dogCnt = stateReg.dogCnt + 17'h1;
        end
        // mode is frozen in this state until reset
        if (stateReg.mode == MODE_SELF_CHECK) begin
          // free-running divider, its top bit sets the blink rate
          stateNext.flashCnt = stateReg.flashCnt + FLASH_STEP;
          if (selfCheckFault != 3'h0) begin
            stateNext.led = {5'h1f, ~selfCheckFault};
          end else begin
            stateNext.led = {8{stateReg.flashCnt[LED_FLASH_BIT]}};
          end
          stateNext.restart = selfCheckPass && (selfCheckFault == 3'h0);
        end else begin
          stateNext.led = userPortOut;
        end
      end
      ST_DOG_RESET: begin
        // stretch the reset pulse, then restart the whole sequence
        stateNext.pulseCnt = stateReg.pulseCnt + 2'h1;
        if (stateReg.pulseCnt == WATCHDOG_PULSE_LAST) begin
          // same image as a pin reset, so the strap pins are sampled again
          stateNext = REGS_RESET;
          // a wait entered on this very cycle must still drop the mask
          stateNext.clearMask = waitEntered;
        end
      end
      default: begin
        stateNext.state = ST_SAMPLE;
      end
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // only register of the block; async clear from the reset pin
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stateReg <= REGS_RESET;
    end else begin
      stateReg <= stateNext;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // mode outcome, all straight from flops
  assign opMode = stateReg.mode;
  assign modeValid = stateReg.modeValid;
  assign startVector = stateReg.startVector;
  // self-check reporting
  assign selfCheckRestart = stateReg.restart;
  assign ledPort = stateReg.led;
  // the strap goes back to port use as soon as the mode is fixed
  assign strapIsPort = stateReg.modeValid;
  // memory window opens for programming only in bootstrap;
  // combinational, so the address must be steady when it is used
  assign progAddrOk = (stateReg.mode == MODE_BOOTSTRAP) &&
                      inRange(progAddr, USER_MEM_START, USER_MEM_END);
  // processor side controls
  assign clearIrqMask = stateReg.clearMask;
  assign deviceReset = stateReg.deviceReset;

endmodule
`default_nettype wire

// file: reset_mode_pkg.sv
`default_nettype none
package reset_mode_pkg;
  // ----------------------------------------
  // mode selection and address map
  // ----------------------------------------
  localparam logic [15:0] SELF_CHECK_START = 16'h3f00;
  localparam logic [15:0] SELF_CHECK_END = 16'h3fdf;
  localparam logic [15:0] USER_MEM_START = 16'h2000;
  localparam logic [15:0] USER_MEM_END = 16'h3eff;
  localparam logic [15:0] USER_VECTOR_DEFAULT = 16'h2000;
  localparam int STRAP_LATCH_CYCLES = 2;
  localparam logic [1:0] STRAP_LATCH_LAST = 2'h1;
  // ----------------------------------------
  // timing counts (10 MHz clock)
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int POR_HOLD_CYCLES = 4064;
  localparam int WATCHDOG_TIMEOUT_CYCLES = 114688;
  localparam int WATCHDOG_PULSE_CYCLES = 2;
  localparam logic [1:0] WATCHDOG_PULSE_LAST = 2'h1;
  localparam logic [7:0] LED_ALL_OFF = 8'hff;
  localparam int LED_FLASH_BIT = 20;

  typedef enum logic [1:0] {
    MODE_UNSET,
    MODE_USER,
    MODE_SELF_CHECK,
    MODE_BOOTSTRAP
  } op_mode_t;

  typedef enum logic [1:0] {
    ST_SAMPLE,
    ST_RUN,
    ST_DOG_RESET
  } seq_state_t;
endpackage
`default_nettype wire

// file: reset_mode_select_assertions.sv
`default_nettype none
// ----------------------------------------
// mode latch and watchdog checks
// ----------------------------------------
module reset_mode_select_assertions
  import reset_mode_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [2:0] selfCheckFault,
  input wire logic selfCheckPass,
  input wire logic waitEntered,
  input wire logic [1:0] opMode,
  input wire logic modeValid,
  input wire logic [15:0] startVector,
  input wire logic selfCheckRestart,
  input wire logic [7:0] ledPort,
  input wire logic strapIsPort,
  input wire logic clearIrqMask,
  input wire logic deviceReset
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // mode choice timing and hold
  latch_time_a: assert property (
    $rose(reset_n) |-> !modeValid ##2 modeValid) else $error("mode latch late");
  mode_hold_a: assert property (
    modeValid && !deviceReset |=> $stable(opMode) || deviceReset) else $error("mode moved");
  vector_ok_a: assert property (
    modeValid |-> startVector == (opMode == 2'h2 ? SELF_CHECK_START : USER_VECTOR_DEFAULT))
    else $error("bad start vector");
  strap_port_a: assert property (
    $rose(reset_n) |-> !strapIsPort ##2 strapIsPort) else $error("strap not released");
  irq_mask_a: assert property (
    waitEntered |=> clearIrqMask) else $error("mask not cleared");
  // self-check reporting, a 0 lights an LED
  check_loop_a: assert property (
    selfCheckPass && selfCheckFault == 3'h0 && opMode == 2'h2 && !deviceReset
    |=> selfCheckRestart) else $error("no restart");
  fault_led_a: assert property (
    opMode == 2'h2 && selfCheckFault != 3'h0 && !deviceReset
    |=> ledPort == {5'h1f, ~$past(selfCheckFault)}) else $error("bad fault pattern");
  dog_pulse_a: assert property (
    $rose(deviceReset) |=> deviceReset ##1 !deviceReset) else $error("bad reset pulse");
  cover property (modeValid && opMode == 2'h2);
  cover property (selfCheckRestart);
  cover property (modeValid && opMode == 2'h3);
  cover property (deviceReset);
endmodule
bind reset_mode_select reset_mode_select_assertions u_chk (.clk, .reset_n, .selfCheckFault,
  .selfCheckPass, .waitEntered, .opMode, .modeValid, .startVector, .selfCheckRestart,
  .ledPort, .strapIsPort, .clearIrqMask, .deviceReset);
`default_nettype wire

// file: board_model.sv
`default_nettype none
// ----------------------------------------
// board reset and strap circuit
// ----------------------------------------
module board_model (
  input wire logic clk,
  output logic reset_n,
  output logic irqElevated,
  output logic modeStrapPin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reset_n = 1'b0;
    irqElevated = 1'b0;
    modeStrapPin = 1'b0;
  end
  // pins then flip, as normal port use would
  task automatic boot(input logic irq, input logic strap, input int hold);
    @(posedge clk) reset_n <= 1'b0;
    irqElevated <= irq;
    modeStrapPin <= strap;
    repeat (hold) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    irqElevated <= ~irq;
    modeStrapPin <= ~strap;
  endtask
endmodule
`default_nettype wire

// file: reset_mode_select_test.sv
`default_nettype none
// ----------------------------------------
// scenarios and verdict
// ----------------------------------------
module reset_mode_select_test;
  import reset_mode_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset_n, irqElevated, modeStrapPin, watchdogService, waitEntered;
  logic selfCheckPass, modeValid, selfCheckRestart, clearIrqMask, deviceReset;
  logic strapIsPort, progAddrOk, waitActive;
  logic [2:0] selfCheckFault;
  logic [1:0] opMode;
  logic [7:0] userPortOut, ledPort;
  logic [15:0] startVector, progAddr;
  int failCount, comparisons;
  board_model board (.clk, .reset_n, .irqElevated, .modeStrapPin);
  // short watchdog so expiry fits the run
  reset_mode_select #(.WatchdogCycles(16), .Programmable(1'b1)) u_dut (.clk, .reset_n,
    .irqElevated, .modeStrapPin, .watchdogService, .waitActive, .waitEntered,
    .selfCheckFault, .selfCheckPass, .userPortOut, .progAddr, .opMode,
    .modeValid, .startVector, .selfCheckRestart, .ledPort, .strapIsPort,
    .progAddrOk, .clearIrqMask, .deviceReset);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failCount++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("%0d compares, %0d mismatches", comparisons, failCount);
    if (failCount == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic t_user;
    board.boot(1'b0, 1'b1, 16);
    repeat (2) @(posedge clk);
    waitEntered <= 1'b1;
    @(posedge clk) waitEntered <= 1'b0;
    #1 chk(opMode, 16'h1);
    chk(startVector, USER_VECTOR_DEFAULT);
    chk(ledPort, userPortOut);
    chk(clearIrqMask, 16'h1);
    chk(modeValid, 16'h1);
    chk(strapIsPort, 16'h1);
    $display("user mode done");
  endtask
  task automatic t_check;
    board.boot(1'b1, 1'b0, 4);
    @(posedge clk) selfCheckFault <= 3'h5;
    @(posedge clk) selfCheckFault <= 3'h0;
    selfCheckPass <= 1'b1;
    #1 chk(ledPort, 16'hfa);
    @(posedge clk) selfCheckPass <= 1'b0;
    #1 chk(selfCheckRestart, 16'h1);
    chk(opMode, 16'h2);
    chk(startVector, SELF_CHECK_START);
    chk(progAddrOk, 16'h0);
    $display("self-check done");
  endtask
  // power-on hold of POR_HOLD_CYCLES, with irq and strap both high for bootstrap entry
  task automatic t_boot;
    board.boot(1'b1, 1'b1, POR_HOLD_CYCLES);
    progAddr <= USER_MEM_END;
    #1 chk(opMode, 16'h3);
    chk(startVector, USER_MEM_START);
    chk(progAddrOk, 16'h1);
    @(posedge clk) progAddr <= SELF_CHECK_START;
    #1 chk(progAddrOk, 16'h0);
    @(posedge clk) progAddr <= USER_MEM_START - 16'h1;
    #1 chk(progAddrOk, 16'h0);
    @(posedge clk) progAddr <= USER_MEM_START;
    #1 chk(progAddrOk, 16'h1);
    $display("bootstrap done");
  endtask
  // serviced run first, then left to expire
  task automatic t_dog;
    int n;
    n = 0;
    repeat (5) begin
      repeat (8) @(posedge clk);
      watchdogService <= 1'b1;
      @(posedge clk) watchdogService <= 1'b0;
    end
    waitActive <= 1'b1;
    #1 chk(deviceReset, 16'h0);
    while (deviceReset !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1 n++;
    end
    chk(deviceReset, 16'h1);
    $display("watchdog done");
  endtask
  initial begin
    failCount = 0;
    comparisons = 0;
    watchdogService = 1'b0;
    waitEntered = 1'b0;
    selfCheckPass = 1'b0;
    selfCheckFault = 3'h0;
    userPortOut = 8'h5a;
    progAddr = 16'h2100;
    waitActive = 1'b0;
    t_user;
    t_check;
    t_boot;
    t_dog;
    close_out;
  end
endmodule
`default_nettype wire
